// ===== core/scr_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "scr_params.svh"

module scr_regs (
    input  wire logic              clk_i,          // Core clock, 40 MHz.
    input  wire logic              rst_i,          // Asynchronous reset, active high.
    input  wire logic              ce_i,           // Clock enable, freezes state when low.
    input  wire logic              psel_i,         // APB select.
    input  wire logic              penable_i,      // APB enable.
    input  wire logic              pwrite_i,       // APB write.
    input  wire logic [11:0]       paddr_i,        // APB byte address.
    input  wire logic [31:0]       pwdata_i,       // APB write data.
    output logic      [31:0]       prdata_o,       // APB read data.
    output logic                   pready_o,       // APB ready.
    output logic                   pslverr_o,      // APB error on unmapped address.
    input  wire logic              big_endian_i,   // Byte order strap, static.
    input  wire scr_pkg::scr_evt_s evt_i,          // Core events, same clock.
    input  wire logic [7:0]        new_pri_i,      // Priority of arriving exception.
    input  wire logic [7:0]        cur_pri_i,      // Priority of running exception.
    output logic                   preempt_o,      // Arriving exception preempts.
    output logic                   wake_o,         // Wake request pulse.
    output logic                   sleep_o,        // Enter sleep pulse.
    output logic                   deep_sleep_o,   // Low power mode is deep sleep.
    output logic                   sys_reset_req_o, // Reset request to outer system.
    output logic                   div_fault_o,    // Divide by zero usage fault.
    output logic                   div_zero_quot_o, // Force quotient to zero.
    output logic                   unal_fault_o,   // Unaligned access usage fault.
    output logic      [31:0]       vector_base_o,  // Vector table base address.
    output scr_pkg::scr_cfg_s      cfg_o           // Configuration controls.
);

    // Group priority mask: bits above the split point are compared.
    function automatic logic [7:0] group_mask(input logic [2:0] split);
        logic [7:0] m;
        m = 8'hFF;
        for (int i = 0; i < 8; i++) begin
            if (i <= int'(split)) begin
                m[i] = 1'b0;
            end
        end
        return m;
    endfunction : group_mask

    scr_pkg::scr_phase_e phase_q;
    logic [22:0]         vbase_q;
    logic [2:0]          split_q;
    scr_pkg::scr_sleep_s sleep_q;
    scr_pkg::scr_cfg_s   cfg_q;
    logic                endian_q;
    logic [2:0]          strap_sync_q;

    // Decode of the current transfer.
    wire        access_w  = psel_i && penable_i && (phase_q == scr_pkg::SCR_ACCESS);
    wire        wr_w      = access_w && pwrite_i;
    wire        hit_vb_w  = (paddr_i == `SCR_OFF_VBASE);
    wire        hit_ai_w  = (paddr_i == `SCR_OFF_AIRC);
    wire        hit_sl_w  = (paddr_i == `SCR_OFF_SLEEP);
    wire        hit_cf_w  = (paddr_i == `SCR_OFF_CFG);
    wire        hit_st_w  = (paddr_i == `SCR_OFF_STATUS);
    wire        mapped_w  = hit_vb_w | hit_ai_w | hit_sl_w | hit_cf_w | hit_st_w;
    wire        key_ok_w  = (pwdata_i[`SCR_KEY_HI:`SCR_KEY_LO] == `SCR_KEY_WRITE);
    wire        ai_wr_w   = wr_w && hit_ai_w && key_ok_w;

    // Read views; unlisted and debug bits stay zero.
    wire [31:0] vb_rd_w = {2'b00, vbase_q, 7'b000_0000};
    wire [31:0] ai_rd_w = {`SCR_KEY_READ, endian_q, 4'h0, split_q, 8'h00};
    wire [31:0] sl_rd_w = {27'h000_0000, sleep_q.wake_on_any_pending, 1'b0,
                           sleep_q.deep_sleep_select, sleep_q.sleep_after_handler, 1'b0};
    wire [31:0] cf_rd_w = {22'h00_0000, cfg_q.stack_align_8byte,
                           cfg_q.high_priority_busfault_ignore, 3'b000,
                           cfg_q.divide_zero_trap_en, cfg_q.misaligned_trap_en, 1'b0,
                           cfg_q.unprivileged_trigger_access,
                           cfg_q.thread_entry_any_level};
    wire [31:0] st_rd_w = {29'h0000_0000, sys_reset_req_o, deep_sleep_o, preempt_o};
    wire [31:0] rd_w    = hit_vb_w ? vb_rd_w :
                          hit_ai_w ? ai_rd_w :
                          hit_sl_w ? sl_rd_w :
                          hit_cf_w ? cf_rd_w :
                          hit_st_w ? st_rd_w : 32'h0000_0000;

    // Core behaviour derived from the stored controls.
    wire [7:0]  gm_w      = group_mask(split_q);
    wire        preempt_w = (new_pri_i & gm_w) < (cur_pri_i & gm_w);
    wire        wake_w    = evt_i.wfi_sleeping &&
                            (evt_i.pend_enabled || evt_i.event_enabled ||
                             (sleep_q.wake_on_any_pending && evt_i.pend_disabled) ||
                             evt_i.send_event_instruction || evt_i.external_event);
    wire        sleep_w   = evt_i.handler_return && sleep_q.sleep_after_handler;

    // APB phase: setup then a single-cycle access; zero wait states.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q <= scr_pkg::SCR_IDLE;
        end else if (ce_i) begin
            case (phase_q)
                scr_pkg::SCR_IDLE:   phase_q <= (psel_i && !penable_i) ? scr_pkg::SCR_ACCESS
                                                                       : scr_pkg::SCR_IDLE;
                scr_pkg::SCR_ACCESS: phase_q <= scr_pkg::SCR_IDLE;
                default:             phase_q <= scr_pkg::SCR_IDLE;
            endcase
        end
    end

    // Bus answer registers; ready pulses in the cycle after setup.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= `SCR_RESET_WORD;
        end else if (ce_i) begin
            pready_o  <= (phase_q == scr_pkg::SCR_IDLE) && psel_i && !penable_i;
            pslverr_o <= (phase_q == scr_pkg::SCR_IDLE) && psel_i && !penable_i && !mapped_w;
            prdata_o  <= rd_w;
        end
    end

    // The byte order strap is static but foreign, so it passes three flops.
    // Only the second and third stages are read, so a metastable first stage
    // never reaches the status bit; a change counts once those two agree.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_sync_q <= 3'b000;
            endian_q     <= 1'b0;
        end else if (ce_i) begin
            strap_sync_q <= {strap_sync_q[1:0], big_endian_i};
            if (strap_sync_q[2] == strap_sync_q[1]) begin
                endian_q <= strap_sync_q[2];
            end
        end
    end

    // Software writable fields.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vbase_q <= 23'h00_0000;
            split_q <= 3'h0;
            sleep_q <= '0;
            cfg_q   <= '0;
        end else if (ce_i) begin
            if (wr_w && hit_vb_w) begin
                vbase_q <= pwdata_i[`SCR_VB_HI:`SCR_VB_LO];
            end
            if (ai_wr_w) begin
                split_q <= pwdata_i[`SCR_AI_SPLIT_HI:`SCR_AI_SPLIT_LO];
            end
            if (wr_w && hit_sl_w) begin
                sleep_q.wake_on_any_pending <= pwdata_i[`SCR_SL_ANYPEND];
                sleep_q.deep_sleep_select   <= pwdata_i[`SCR_SL_DEEP];
                sleep_q.sleep_after_handler <= pwdata_i[`SCR_SL_EXIT];
            end
            if (wr_w && hit_cf_w) begin
                cfg_q.stack_align_8byte             <= pwdata_i[`SCR_CF_STK8];
                cfg_q.high_priority_busfault_ignore <= pwdata_i[`SCR_CF_BFIGN];
                cfg_q.divide_zero_trap_en           <= pwdata_i[`SCR_CF_DIV0];
                cfg_q.misaligned_trap_en            <= pwdata_i[`SCR_CF_UNAL];
                cfg_q.unprivileged_trigger_access   <= pwdata_i[`SCR_CF_UNPRIV];
                cfg_q.thread_entry_any_level        <= pwdata_i[`SCR_CF_THREAD];
            end
        end
    end

    // Registered outputs. The reset request stays high until the outer
    // system resets this block; it never reads back through the control word.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_reset_req_o <= 1'b0;
            preempt_o       <= 1'b0;
            wake_o          <= 1'b0;
            sleep_o         <= 1'b0;
            deep_sleep_o    <= 1'b0;
            div_fault_o     <= 1'b0;
            div_zero_quot_o <= 1'b0;
            unal_fault_o    <= 1'b0;
            vector_base_o   <= `SCR_RESET_WORD;
            cfg_o           <= '0;
        end else if (ce_i) begin
            if (ai_wr_w && pwdata_i[`SCR_AI_RSTREQ]) begin
                sys_reset_req_o <= 1'b1;
            end
            preempt_o       <= preempt_w;
            wake_o          <= wake_w;
            sleep_o         <= sleep_w;
            deep_sleep_o    <= sleep_q.deep_sleep_select;
            div_fault_o     <= evt_i.div_zero && cfg_q.divide_zero_trap_en;
            div_zero_quot_o <= evt_i.div_zero && !cfg_q.divide_zero_trap_en;
            unal_fault_o    <= evt_i.unaligned_half_word && cfg_q.misaligned_trap_en;
            vector_base_o   <= vb_rd_w;
            cfg_o           <= cfg_q;
        end
    end

endmodule : scr_regs
`default_nettype wire

// ===== pkg/scr_params.svh
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// Register byte offsets, chosen locally.
`define SCR_OFF_VBASE    12'h008
`define SCR_OFF_AIRC     12'h00C
`define SCR_OFF_SLEEP    12'h010
`define SCR_OFF_CFG      12'h014
`define SCR_OFF_STATUS   12'h018

// Key handling of the interrupt and reset control register.
`define SCR_KEY_WRITE    16'h05FA
`define SCR_KEY_READ     16'hFA05
`define SCR_KEY_HI       31
`define SCR_KEY_LO       16

// Field positions.
`define SCR_VB_HI        29
`define SCR_VB_LO        7
`define SCR_VB_REGION    29
`define SCR_AI_ENDIAN    15
`define SCR_AI_SPLIT_HI  10
`define SCR_AI_SPLIT_LO  8
`define SCR_AI_RSTREQ    2
`define SCR_SL_ANYPEND   4
`define SCR_SL_DEEP      2
`define SCR_SL_EXIT      1
`define SCR_CF_STK8      9
`define SCR_CF_BFIGN     8
`define SCR_CF_DIV0      4
`define SCR_CF_UNAL      3
`define SCR_CF_UNPRIV    1
`define SCR_CF_THREAD    0

// Reset value of the read data and vector base outputs.
`define SCR_RESET_WORD   32'h0000_0000

`endif

// ===== pkg/scr_pkg.sv
package scr_pkg;

    // Sleep and wake controls handed to the sleep controller.
    typedef struct packed {
        logic wake_on_any_pending;
        logic deep_sleep_select;
        logic sleep_after_handler;
    } scr_sleep_s;

    // Configuration and control outputs.
    typedef struct packed {
        logic stack_align_8byte;
        logic high_priority_busfault_ignore;
        logic divide_zero_trap_en;
        logic misaligned_trap_en;
        logic unprivileged_trigger_access;
        logic thread_entry_any_level;
    } scr_cfg_s;

    // Exception events whose effect this block decides.
    typedef struct packed {
        logic wfi_sleeping;
        logic pend_enabled;
        logic pend_disabled;
        logic event_enabled;
        logic send_event_instruction;
        logic external_event;
        logic handler_return;
        logic div_zero;
        logic unaligned_half_word;
    } scr_evt_s;

    // Access phase tracker.
    typedef enum logic [1:0] {
        SCR_IDLE   = 2'b01,
        SCR_ACCESS = 2'b10
    } scr_phase_e;

endpackage : scr_pkg

// ===== tb/scr_core_model.sv
`timescale 1ns/100ps
`default_nettype none

// Stands in for the core's exception and sleep logic. Events are one-cycle
// pulses from a register, as the core gives them; sleeping is a level.
module scr_core_model (
    input  wire logic         clk_i,      // Clock.
    input  wire logic         sleeping_i, // Core waits in sleep.
    input  wire logic         fire_i,     // Raise one event.
    input  wire logic [2:0]   kind_i,     // Which event.
    output scr_pkg::scr_evt_s evt_o       // Events to the block.
);
    wire logic [7:0] pulse_w = fire_i ? (8'h01 << kind_i) : 8'h00;

    // Register the bundle so it changes only after a clock edge.
    always_ff @(posedge clk_i) begin
        evt_o <= scr_pkg::scr_evt_s'({sleeping_i, pulse_w});
    end
endmodule : scr_core_model
`default_nettype wire

// ===== tb/scr_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "scr_params.svh"

// Port-side checks of the register block; it has one clock domain only.
module scr_regs_monitor (
    input wire logic              clk_i,           // Clock.
    input wire logic              rst_i,           // Reset.
    input wire logic              ce_i,            // Clock enable.
    input wire logic              psel_i,          // Select.
    input wire logic              penable_i,       // Enable.
    input wire logic              pwrite_i,        // Write.
    input wire logic [11:0]       paddr_i,         // Address.
    input wire logic [31:0]       pwdata_i,        // Write data.
    input wire logic [31:0]       prdata_o,        // Read data.
    input wire logic              pready_o,        // Ready.
    input wire scr_pkg::scr_evt_s evt_i,           // Core events.
    input wire logic [7:0]        new_pri_i,       // Arriving priority.
    input wire logic [7:0]        cur_pri_i,       // Running priority.
    input wire logic              preempt_o,       // Preempt.
    input wire logic              wake_o,          // Wake.
    input wire logic              sys_reset_req_o, // Reset request.
    input wire logic              div_fault_o,     // Divide fault.
    input wire logic              div_zero_quot_o, // Zero quotient.
    input wire logic [31:0]       vector_base_o    // Vector base.
);
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Steps of one transfer, and its access phase on the control register.
    sequence setup_s;
        psel_i && !penable_i && ce_i;
    endsequence
    sequence answer_s;
        psel_i && penable_i && pready_o;
    endsequence
    wire logic ai_w = psel_i && penable_i && pready_o && paddr_i == `SCR_OFF_AIRC;
    wire logic key_w = pwdata_i[31:16] == `SCR_KEY_WRITE;

    // A slow answer would stall the core, so zero wait is enforced.
    chk_apb_answer: assert property (setup_s |=> answer_s)
        else $error("No answer in the access cycle.");
    chk_key_read: assert property (
        ai_w && !pwrite_i |-> prdata_o[31:16] == `SCR_KEY_READ && prdata_o[2:0] == 3'h0)
        else $error("Bad key or low bits on readback.");
    chk_keyed_reset: assert property (
        ai_w && pwrite_i && key_w && pwdata_i[2] |=> sys_reset_req_o)
        else $error("Keyed reset request not raised.");
    chk_keyless_none: assert property (
        ai_w && pwrite_i && !key_w && !sys_reset_req_o |=> !sys_reset_req_o)
        else $error("Write without key took effect.");
    chk_reset_sticky: assert property (sys_reset_req_o |=> sys_reset_req_o)
        else $error("Reset request dropped.");
    chk_vbase_low: assert property (
        vector_base_o[6:0] == 7'h00 && vector_base_o[31:30] == 2'h0)
        else $error("Vector base low bits not zero.");
    chk_wake_event: assert property (
        ce_i && evt_i.wfi_sleeping && (evt_i.send_event_instruction || evt_i.external_event)
        |=> wake_o)
        else $error("Event did not wake.");
    chk_group_equal: assert property (ce_i && new_pri_i == cur_pri_i |=> !preempt_o)
        else $error("Equal priority preempted.");
    chk_div_split: assert property (
        ce_i && evt_i.div_zero |=> div_fault_o != div_zero_quot_o)
        else $error("Divide by zero outcome wrong.");
endmodule : scr_regs_monitor

bind scr_regs scr_regs_monitor mon_u (.clk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .evt_i, .new_pri_i, .cur_pri_i, .preempt_o,
    .wake_o, .sys_reset_req_o, .div_fault_o, .div_zero_quot_o, .vector_base_o);
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "scr_params.svh"

module testbench;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0000_0000;
    logic [7:0]        new_pri = 8'h00;
    logic [7:0]        cur_pri = 8'h00;
    logic              sleeping = 1'b0;
    logic              fire = 1'b0;
    logic [2:0]        kind = 3'h0;
    logic [31:0]       rd;
    logic              err;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                i, j;
    wire logic [31:0]  prdata, vbase;
    wire logic         pready, pslverr, preempt, wake, slp, deep, rreq, dflt, dquo, uflt;
    wire scr_pkg::scr_evt_s evt;
    wire scr_pkg::scr_cfg_s cfg;

    // Clock at 40 MHz.
    always #12.5 clk_i = ~clk_i;

    scr_core_model core_u (.clk_i(clk_i), .sleeping_i(sleeping), .fire_i(fire), .kind_i(kind),
        .evt_o(evt));
    scr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .big_endian_i(1'b1),
        .evt_i(evt), .new_pri_i(new_pri), .cur_pri_i(cur_pri), .preempt_o(preempt),
        .wake_o(wake), .sleep_o(slp), .deep_sleep_o(deep), .sys_reset_req_o(rreq),
        .div_fault_o(dflt), .div_zero_quot_o(dquo), .unal_fault_o(uflt),
        .vector_base_o(vbase), .cfg_o(cfg));

    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One transfer; the request stands until ready is seen at an edge.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        for (n = 0; pready !== 1'b1 && n < 16; n++)
            @(posedge clk_i);
        if (n >= 16)
            bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask : rdc

    // Raise one event and wait until the block's answer has landed.
    task ev(input int k);
        @(posedge clk_i);
        fire <= 1'b1;
        kind <= 3'(k);
        @(posedge clk_i);
        fire <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask : ev

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        finish_test;
    end

    // Main sequence; an all-ones write to the base and a write of ones to the low half of the config word check that unlisted bits read zero.
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (i = 0; i < 4; i++)
            rdc("reset", `SCR_OFF_VBASE + 12'(4 * i), i == 1 ? 32'hFA05_8000 : 0);
        apb(1'b1, `SCR_OFF_VBASE, 32'h2000_0080);
        rdc("vbase", `SCR_OFF_VBASE, 32'h2000_0080);
        chk("region", vbase, 32'h2000_0080);
        apb(1'b1, `SCR_OFF_VBASE, 32'h0000_0200);
        rdc("vbase big", `SCR_OFF_VBASE, 32'h0000_0200);
        apb(1'b1, `SCR_OFF_VBASE, 32'hFFFF_FFFF);
        rdc("vbase mask", `SCR_OFF_VBASE, 32'h3FFF_FF80);
        apb(1'b1, `SCR_OFF_AIRC, 32'h0000_0704);
        rdc("no key", `SCR_OFF_AIRC, 32'hFA05_8000);
        for (i = 0; i < 8; i++) begin
            apb(1'b1, `SCR_OFF_AIRC, 32'h05FA_0000 | (i << 8));
            rdc("split", `SCR_OFF_AIRC, 32'hFA05_8000 | (i << 8));
            new_pri <= 8'h00;
            cur_pri <= 8'(1 << i);
            repeat (2) @(posedge clk_i);
            #1;
            chk("sub only", preempt, 0);
            cur_pri <= 8'(2 << i);
            repeat (2) @(posedge clk_i);
            #1;
            chk("group", preempt, i < 7);
        end
        sleeping <= 1'b1;
        for (j = 0; j < 2; j++) begin
            apb(1'b1, `SCR_OFF_SLEEP, j << 4);
            for (i = 3; i < 8; i++) begin
                ev(i);
                chk("wake", wake, i != 6 || j == 1);
            end
        end
        sleeping <= 1'b0;
        for (j = 1; j >= 0; j--) begin
            apb(1'b1, `SCR_OFF_SLEEP, j * 6);
            ev(2);
            chk("sleep exit", slp, j);
            chk("deep", deep, j);
        end
        apb(1'b1, `SCR_OFF_CFG, 32'h0000_FFFF);
        rdc("cfg", `SCR_OFF_CFG, 32'h0000_031B);
        chk("cfg out", cfg, 32'h3F);
        ev(1);
        chk("div trap", {dflt, dquo}, 2'b10);
        ev(0);
        chk("unal trap", uflt, 1);
        apb(1'b1, `SCR_OFF_CFG, 32'h0000_0000);
        ev(1);
        chk("div quiet", {dflt, dquo}, 2'b01);
        ev(0);
        chk("unal quiet", uflt, 0);
        apb(1'b1, `SCR_OFF_AIRC, 32'h05FA_0004);
        rdc("rst bit", `SCR_OFF_AIRC, 32'hFA05_8000);
        rdc("status", `SCR_OFF_STATUS, 32'h0000_0004);
        rdc("unmapped", 12'h0FC, 0);
        chk("unmapped err", err, 1);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("req cleared", rreq, 0);
        rdc("airc again", `SCR_OFF_AIRC, 32'hFA05_8000);
        finish_test;
    end
endmodule : testbench
`default_nettype wire
